/* File: design/cyctc_pkg.sv */
// holds the constants and types shared by the cycle timing and clock out block
// assumes a 25 MHz core clock and register access over AXI4-Lite
//
// Function
// - timing field bits 6..4 gives clocks per machine cycle as value plus one
// - control register resets to 10H, two clocks per machine cycle
// - new timing value written at index 8Eh applies at once, no reset
// - port 3 bit 5 drives the clock out chosen by bits 1..0
// - clock out select is writable any time, pin follows new selection
package cyctc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_INDEX = 8'h8E;
  localparam logic [11:0] CTL_ADDR = {2'h0, CTL_INDEX, 2'h0};
  localparam logic [7:0] CTL_RESET = 8'h10;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h73;
  localparam int ITS_LSB = 4;
  localparam int SEL_LSB = 0;
  localparam int ADDR_BITS = 12;
  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // clock out modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_SEL_GPIO = 2'b00,
    CLK_SEL_FULL = 2'b01,
    CLK_SEL_HALF = 2'b10,
    CLK_SEL_QUARTER = 2'b11
  } cyctc_sel_e;
  // control register layout
  typedef struct packed {
    logic spare7;
    logic [2:0] timingSelect;
    logic [1:0] spare32;
    cyctc_sel_e clockOutSelect;
  } cyctc_ctl_s;
endpackage

/* File: design/cyctc_top.sv */
// cycle timing selector, machine cycle strobe and clock out for port 3 bit 5
// assumes one clock domain and an AXI4-Lite master for register access
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cyctc_top
  import cyctc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic [ADDR_BITS-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_BITS-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core timing
  output logic machineCycleStrobe,
  // port 3 bit 5 pin and its gpio source
  input wire logic gpioOut,
  input wire logic gpioOe,
  input wire logic port3Bit5PinIn,
  output logic port3Bit5PinOut,
  output logic port3Bit5PinOe,
  output logic port3Bit5Sync
);
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  cyctc_ctl_s ctl;
  logic awHeld;
  logic wHeld;
  logic [ADDR_BITS-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic [7:0] next_ctl;

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  // address and data are caught in either order, ready flops drop while held
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // a lowered ready flop means that channel's item is held
  assign awHeld = !s_axi_awready;
  assign wHeld = !s_axi_wready;

  // write response, slverr for any address other than the control word
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr == CTL_ADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only writable bits change, spare bits stay zero
  assign next_ctl = (wData[7:0] & CTL_WRITE_MASK) | (ctl & ~CTL_WRITE_MASK);

  // control register, taken any time while running
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl <= CTL_RESET;
    end else if (doWrite && awAddr == CTL_ADDR && wStrb[0]) begin
      ctl <= next_ctl;
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == CTL_ADDR) begin
        s_axi_rdata <= {24'h000000, ctl};
        s_axi_rresp <= RESP_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_arready <= 1'b1; // ready again as the data is taken
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // machine cycle timing
  // ----------------------------------------------------------------
  logic [2:0] phase;
  logic phaseEnd;

  // a shrunk selector ends the cycle at once instead of wrapping past it
  assign phaseEnd = (phase >= ctl.timingSelect);

  // strobe once every timing value plus one clocks
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 3'h0;
      machineCycleStrobe <= 1'b0;
    end else begin
      phase <= phaseEnd ? 3'h0 : phase + 3'h1;
      machineCycleStrobe <= phaseEnd;
    end
  end

  // ----------------------------------------------------------------
  // clock out on port 3 bit 5
  // ----------------------------------------------------------------
  logic [1:0] divCnt;
  logic syncFirst;

  // free divider, the pin is registered so full rate is a toggle per edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt <= 2'h0;
      port3Bit5PinOut <= 1'b0;
      port3Bit5PinOe <= 1'b0;
    end else begin
      divCnt <= divCnt + 2'h1;
      port3Bit5PinOe <= (ctl.clockOutSelect == CLK_SEL_GPIO) ? gpioOe : 1'b1;
      case (ctl.clockOutSelect)
        CLK_SEL_GPIO: begin
          port3Bit5PinOut <= gpioOut;
        end
        CLK_SEL_FULL: begin
          port3Bit5PinOut <= ~port3Bit5PinOut;
        end
        CLK_SEL_HALF: begin
          port3Bit5PinOut <= divCnt[0] ? ~port3Bit5PinOut : port3Bit5PinOut;
        end
        CLK_SEL_QUARTER: begin
          port3Bit5PinOut <= (divCnt == 2'h3) ? ~port3Bit5PinOut : port3Bit5PinOut;
        end
        default: begin
          port3Bit5PinOut <= 1'b0;
        end
      endcase
    end
  end

  // pin input passes two flops before use
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncFirst <= 1'b0;
      port3Bit5Sync <= 1'b0;
    end else begin
      syncFirst <= port3Bit5PinIn;
      port3Bit5Sync <= syncFirst;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] gapCnt;
  logic itsSteady;

  // cycles since the last strobe, and whether the selector held meanwhile
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gapCnt <= 4'h0;
      itsSteady <= 1'b0;
    end else begin
      gapCnt <= machineCycleStrobe ? 4'h1 : gapCnt + 4'h1;
      if (machineCycleStrobe) begin
        itsSteady <= 1'b1;
      end else if (ctl.timingSelect != $past(ctl.timingSelect)) begin
        itsSteady <= 1'b0;
      end
    end
  end

  sequence ctlWrite;
    doWrite && awAddr == CTL_ADDR && wStrb[0];
  endsequence

  sequence ctlRead;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CTL_ADDR;
  endsequence

  a_timing_period: assert property (@(posedge sys_clk) disable iff (sys_rst)
    machineCycleStrobe && itsSteady && $stable(ctl.timingSelect)
      |-> gapCnt == {1'b0, ctl.timingSelect} + 4'h1)
    else $error("machine cycle length wrong");

  a_reset_value: assert property (@(posedge sys_clk)
    $fell(sys_rst) |-> ctl == CTL_RESET && ctl.timingSelect == 3'h1)
    else $error("control register reset value wrong");

  a_timing_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctlWrite |=> ctl.timingSelect == $past(wData[6:4]))
    else $error("timing write not applied");

  a_clock_out_select_full: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctl.clockOutSelect == CLK_SEL_FULL ##1 ctl.clockOutSelect == CLK_SEL_FULL
      |=> port3Bit5PinOut != $past(port3Bit5PinOut) && port3Bit5PinOe)
    else $error("full rate clock out not toggling");

  a_gpio_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctlWrite ##1 ctl.clockOutSelect == CLK_SEL_GPIO
      |=> port3Bit5PinOut == $past(gpioOut) && port3Bit5PinOe == $past(gpioOe))
    else $error("pin does not follow gpio after select write");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctlRead |=> s_axi_rvalid && s_axi_rdata[7] == 1'b0 && s_axi_rdata[3:2] == 2'h0)
    else $error("spare bits read nonzero");
endmodule // cyctc_top
`default_nettype wire

/* File: verif/cyctc_top_tb_top.sv */
// bench for the cycle timing and clock out block, with a byte model of the control word
// assumes the block package is compiled first and the block answers every bus request
`timescale 1ns/1ps
`default_nettype none
module cyctc_top_tb_top;
  import cyctc_pkg::*;
  logic sys_clk, sys_rst;
  logic [ADDR_BITS-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, machineCycleStrobe;
  logic gpioOut, gpioOe, port3Bit5PinIn, port3Bit5PinOut, port3Bit5PinOe, port3Bit5Sync;
  logic [7:0] mdl;
  int fails, n_checks, p;

  cyctc_top i_dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .machineCycleStrobe, .gpioOut, .gpioOe,
    .port3Bit5PinIn, .port3Bit5PinOut, .port3Bit5PinOe, .port3Bit5Sync);

  // 25 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one write then one read back, both compared with the model
  task automatic acc(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] ex;
    ex = (a == CTL_ADDR) ? RESP_OKAY : RESP_SLVERR;
    if (a == CTL_ADDR && s[0]) mdl = d[7:0] & 8'h73;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, ex);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, (a == CTL_ADDR) ? {24'h0, mdl} : 32'h0);
    chk(s_axi_rresp, ex);
  endtask

  // machine cycle length in clocks; the first span may be cut short
  task automatic per(output int n);
    repeat (2) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (machineCycleStrobe !== 1'b1);
    end
  endtask

  // clocks between two pin transitions
  task automatic half(output int n);
    logic v;
    @(negedge sys_clk);
    repeat (2) begin
      n = 0;
      v = port3Bit5PinOut;
      do begin
        @(negedge sys_clk);
        n++;
      end while (port3Bit5PinOut === v);
    end
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, gpioOut, gpioOe, port3Bit5PinIn} = '0;
    p = $urandom(29457);
    mdl = 8'h10;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    acc(CTL_ADDR, $urandom, 4'hE);
    per(p);
    chk(p, 2);
    for (int t = 0; t < 8; t++) begin
      acc(CTL_ADDR, ($urandom & 32'hFFFFFF8F) | 32'(t << 4), 4'h1 | 4'($urandom));
      per(p);
      chk(p, t + 1);
    end
    acc(CTL_ADDR + 12'h4, $urandom, 4'hF);
    for (int s = 3; s >= 0; s--) begin
      acc(CTL_ADDR, 32'(s), 4'h1);
      if (s > 0) begin
        half(p);
        chk(p, 1 << (s - 1));
        chk(port3Bit5PinOe, 1'b1);
      end else begin
        repeat (4) begin
          @(posedge sys_clk);
          gpioOut <= 1'($urandom);
          gpioOe <= 1'($urandom);
          port3Bit5PinIn <= 1'($urandom);
          @(posedge sys_clk);
          @(negedge sys_clk);
          chk({port3Bit5PinOut, port3Bit5PinOe}, {gpioOut, gpioOe});
          @(posedge sys_clk);
          @(negedge sys_clk);
          chk(port3Bit5Sync, port3Bit5PinIn);
        end
      end
    end
    results;
  end

  // cuts a hang short
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    results;
  end
endmodule // cyctc_top_tb_top
`default_nettype wire
